// ==== rtl/ucp_cache.sv ====
// unified four-way code/data cache controller with burst line fill
`timescale 1ns/1ps
module ucp_cache import ucp_pkg::*; #(
    parameter bit LARGE = 1'b0
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_wb_mode,
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic i_req_code,
    input wire logic i_req_cacheable,
    input wire logic [ADDR_W-1:0] i_req_addr,
    input wire logic [DATA_W-1:0] i_req_wdata,
    input wire logic i_bus_ack,
    input wire logic [DATA_W-1:0] i_bus_rdata,
    output logic o_req_ready,
    output logic o_rsp_valid,
    output logic o_rsp_code,
    output logic [DATA_W-1:0] o_rsp_rdata,
    output logic o_bus_req,
    output logic o_bus_write,
    output logic o_bus_burst,
    output logic [ADDR_W-1:0] o_bus_addr,
    output logic [DATA_W-1:0] o_bus_wdata
);
    // geometry: 128 or 256 sets of four 16-byte lines gives 8 or 16 KB
    localparam int IDX_W = LARGE ? IDX_W_LARGE : IDX_W_SMALL;
    localparam int TAG_W = ADDR_W - OFF_W - IDX_W;
    localparam int SEL_W = WAY_W + IDX_W + WORD_W;
    localparam int MEM_WORDS = 1 << SEL_W;

    ucp_tag_if #(.IDX_W(IDX_W), .TAG_W(TAG_W)) tif ();

    ucp_tag_store #(.IDX_W(IDX_W), .TAG_W(TAG_W)) u_tags (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .tif(tif)
    );

    // unified data array: code and data share every line
    logic [DATA_W-1:0] data_mem [MEM_WORDS];

    ucp_state_t state_r, state_nxt;
    logic [ADDR_W-1:0] req_addr_r, req_addr_nxt;
    logic [DATA_W-1:0] req_wdata_r, req_wdata_nxt;
    logic req_write_r, req_write_nxt;
    logic req_code_r, req_code_nxt;
    logic req_cache_r, req_cache_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic [1:0] way_r, way_nxt;
    logic ready_r, ready_nxt;
    logic rsp_valid_r, rsp_valid_nxt;
    logic [DATA_W-1:0] rsp_rdata_r, rsp_rdata_nxt;
    logic bus_req_r, bus_req_nxt;
    logic bus_write_r, bus_write_nxt;
    logic bus_burst_r, bus_burst_nxt;
    logic [ADDR_W-1:0] bus_addr_r, bus_addr_nxt;
    logic [DATA_W-1:0] bus_wdata_r, bus_wdata_nxt;

    logic [IDX_W-1:0] idx;
    logic [TAG_W-1:0] tag;
    logic [1:0] word;
    logic [1:0] fill_word;
    logic wb_eff;
    logic [SEL_W-1:0] rd_sel;
    logic [DATA_W-1:0] mem_rd;
    logic mem_we;
    logic [SEL_W-1:0] mem_wsel;
    logic [DATA_W-1:0] mem_wdata;

    // address split of the held request
    assign idx = req_addr_r[OFF_W +: IDX_W];
    assign tag = req_addr_r[ADDR_W-1 -: TAG_W];
    assign word = req_addr_r[OFF_W-1 -: WORD_W];
    assign fill_word = word + cnt_r; // wrapping order, requested word first
    assign wb_eff = LARGE && i_wb_mode; // write-back only exists on the large build
    assign tif.index = idx;
    assign tif.look_tag = tag;

    // data array read address: hit word, or the victim word being written out
    always_comb begin
        rd_sel = '0;
        unique case (state_r)
            ST_LOOK: rd_sel = tif.hit ? {tif.hit_way, idx, word} : {tif.vic_way, idx, 2'h0};
            ST_EVICT: rd_sel = {way_r, idx, 2'(cnt_r + 2'h1)};
            ST_IDLE, ST_SINGLE, ST_FILL: rd_sel = '0;
        endcase
    end
    assign mem_rd = data_mem[rd_sel];

    // controller next state
    always_comb begin
        state_nxt = state_r;
        req_addr_nxt = req_addr_r;
        req_wdata_nxt = req_wdata_r;
        req_write_nxt = req_write_r;
        req_code_nxt = req_code_r;
        req_cache_nxt = req_cache_r;
        cnt_nxt = cnt_r;
        way_nxt = way_r;
        ready_nxt = ready_r;
        rsp_valid_nxt = 1'b0;
        rsp_rdata_nxt = rsp_rdata_r;
        bus_req_nxt = bus_req_r;
        bus_write_nxt = bus_write_r;
        bus_burst_nxt = bus_burst_r;
        bus_addr_nxt = bus_addr_r;
        bus_wdata_nxt = bus_wdata_r;
        mem_we = 1'b0;
        mem_wsel = '0;
        mem_wdata = '0;
        tif.upd_en = 1'b0;
        tif.upd_way = tif.vic_way;
        tif.upd_valid = 1'b0;
        tif.upd_dirty = 1'b0;
        tif.upd_tag = tag;
        tif.touch_en = 1'b0;
        tif.touch_way = tif.hit_way;
        unique case (state_r)
            ST_IDLE: begin
                if (i_req_valid && ready_r) begin
                    req_addr_nxt = i_req_addr;
                    req_wdata_nxt = i_req_wdata;
                    req_write_nxt = i_req_write;
                    req_code_nxt = i_req_code; // prefetch or data read
                    req_cache_nxt = i_req_cacheable;
                    ready_nxt = 1'b0;
                    state_nxt = ST_LOOK;
                end
            end
            ST_LOOK: begin
                if (req_write_r) begin
                    if (tif.hit) begin
                        mem_we = 1'b1; // cached copy follows the write
                        mem_wsel = {tif.hit_way, idx, word};
                        mem_wdata = req_wdata_r;
                        tif.touch_en = 1'b1;
                    end
                    if (tif.hit && wb_eff) begin
                        tif.upd_en = 1'b1; // memory update deferred to eviction
                        tif.upd_way = tif.hit_way;
                        tif.upd_valid = 1'b1;
                        tif.upd_dirty = 1'b1;
                        ready_nxt = 1'b1;
                        state_nxt = ST_IDLE;
                    end else begin
                        bus_req_nxt = 1'b1; // hit or miss, the write goes out
                        bus_write_nxt = 1'b1;
                        bus_burst_nxt = 1'b0;
                        bus_addr_nxt = req_addr_r;
                        bus_wdata_nxt = req_wdata_r;
                        state_nxt = ST_SINGLE;
                    end
                end else if (tif.hit) begin
                    rsp_valid_nxt = 1'b1;
                    rsp_rdata_nxt = mem_rd;
                    tif.touch_en = 1'b1;
                    ready_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end else if (!req_cache_r) begin
                    bus_req_nxt = 1'b1; // plain read, nothing allocated
                    bus_write_nxt = 1'b0;
                    bus_burst_nxt = 1'b0;
                    bus_addr_nxt = req_addr_r;
                    state_nxt = ST_SINGLE;
                end else begin
                    // victim drops to invalid before any word of it changes
                    tif.upd_en = 1'b1;
                    way_nxt = tif.vic_way;
                    cnt_nxt = 2'h0;
                    bus_req_nxt = 1'b1;
                    bus_burst_nxt = 1'b1;
                    if (tif.vic_dirty) begin
                        bus_write_nxt = 1'b1;
                        bus_addr_nxt = {tif.vic_tag, idx, {OFF_W{1'b0}}};
                        bus_wdata_nxt = mem_rd;
                        state_nxt = ST_EVICT;
                    end else begin
                        bus_write_nxt = 1'b0; // line fill
                        bus_addr_nxt = {tag, idx, word, 2'h0};
                        state_nxt = ST_FILL;
                    end
                end
            end
            ST_SINGLE: begin
                if (i_bus_ack) begin
                    bus_req_nxt = 1'b0;
                    bus_write_nxt = 1'b0;
                    rsp_valid_nxt = !req_write_r;
                    rsp_rdata_nxt = req_write_r ? rsp_rdata_r : i_bus_rdata;
                    ready_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            ST_EVICT: begin
                if (i_bus_ack) begin
                    cnt_nxt = cnt_r + 2'h1;
                    bus_addr_nxt = bus_addr_r + ADDR_W'(WORDS_PER_LINE);
                    bus_wdata_nxt = mem_rd;
                    if (cnt_r == LAST_WORD) begin
                        // line is now clean and invalid; look again to start the fill
                        bus_req_nxt = 1'b0;
                        bus_write_nxt = 1'b0;
                        bus_burst_nxt = 1'b0;
                        state_nxt = ST_LOOK;
                    end
                end
            end
            ST_FILL: begin
                if (i_bus_ack) begin
                    // one word per acknowledged clock, four per line
                    mem_we = 1'b1;
                    mem_wsel = {way_r, idx, fill_word};
                    mem_wdata = i_bus_rdata;
                    cnt_nxt = cnt_r + 2'h1;
                    bus_addr_nxt = {tag, idx, 2'(fill_word + 2'h1), 2'h0};
                    if (cnt_r == 2'h0) begin
                        rsp_valid_nxt = 1'b1; // bypass: requester need not wait
                        rsp_rdata_nxt = i_bus_rdata;
                    end
                    if (cnt_r == LAST_WORD) begin
                        tif.upd_en = 1'b1; // whole line present, mark it valid
                        tif.upd_way = way_r;
                        tif.upd_valid = 1'b1;
                        tif.touch_en = 1'b1;
                        tif.touch_way = way_r;
                        bus_req_nxt = 1'b0;
                        bus_burst_nxt = 1'b0;
                        ready_nxt = 1'b1;
                        state_nxt = ST_IDLE;
                    end
                end
            end
        endcase
    end

    // data array writes; no reset, contents only matter under a valid tag
    always_ff @(posedge i_ref_clk) begin
        if (mem_we) begin
            data_mem[mem_wsel] <= mem_wdata;
        end
    end

    // controller registers
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= ST_IDLE;
            req_addr_r <= '0;
            req_wdata_r <= '0;
            req_write_r <= 1'b0;
            req_code_r <= 1'b0;
            req_cache_r <= 1'b0;
            cnt_r <= 2'h0;
            way_r <= 2'h0;
            ready_r <= 1'b1;
            rsp_valid_r <= 1'b0;
            rsp_rdata_r <= '0;
            bus_req_r <= 1'b0;
            bus_write_r <= 1'b0;
            bus_burst_r <= 1'b0;
            bus_addr_r <= '0;
            bus_wdata_r <= '0;
        end else begin
            state_r <= state_nxt;
            req_addr_r <= req_addr_nxt;
            req_wdata_r <= req_wdata_nxt;
            req_write_r <= req_write_nxt;
            req_code_r <= req_code_nxt;
            req_cache_r <= req_cache_nxt;
            cnt_r <= cnt_nxt;
            way_r <= way_nxt;
            ready_r <= ready_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_rdata_r <= rsp_rdata_nxt;
            bus_req_r <= bus_req_nxt;
            bus_write_r <= bus_write_nxt;
            bus_burst_r <= bus_burst_nxt;
            bus_addr_r <= bus_addr_nxt;
            bus_wdata_r <= bus_wdata_nxt;
        end
    end

    assign o_req_ready = ready_r;
    assign o_rsp_valid = rsp_valid_r;
    assign o_rsp_code = req_code_r;
    assign o_rsp_rdata = rsp_rdata_r;
    assign o_bus_req = bus_req_r;
    assign o_bus_write = bus_write_r;
    assign o_bus_burst = bus_burst_r;
    assign o_bus_addr = bus_addr_r;
    assign o_bus_wdata = bus_wdata_r;
endmodule : ucp_cache

// ==== pkg/ucp_pkg.sv ====
// constants shared by the unified cache controller and its tag store
// Functional notes
// - cache capacity 8 KB, or 16 KB large
// - unified array, four ways of 2/4 KB
// - each way 128 or 256 lines
// - lines are sixteen aligned bytes
// - validity tracked per whole line only
// - code and data reads; miss goes external
// - non-cacheable miss: one plain read, no allocation
// - cacheable miss starts a full line fill
// - four bytes per transfer, four transfers
// - burst moves a word every clock
// - write-through: every write goes external
// - write hit also updates cached copy
// - large write-back: hit updates cache only
// - first fill transfer goes straight to requester
package ucp_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int WAYS = 4;
    localparam int WAY_W = 2;
    localparam int LINE_BYTES = 16;
    localparam int WORDS_PER_LINE = 4;
    localparam int WORD_W = 2;
    localparam int OFF_W = 4;
    localparam int IDX_W_SMALL = 7;
    localparam int IDX_W_LARGE = 8;
    localparam int CAP_KB_SMALL = 8;
    localparam int CAP_KB_LARGE = 16;
    localparam int PLRU_W = 3;
    localparam int CLK_PERIOD_NS = 20;
    localparam int FILL_MIN_CLOCKS = 5;
    localparam logic [1:0] LAST_WORD = 2'h3;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_LOOK   = 5'b00010,
        ST_SINGLE = 5'b00100,
        ST_EVICT  = 5'b01000,
        ST_FILL   = 5'b10000
    } ucp_state_t;
endpackage : ucp_pkg

// ==== pkg/ucp_tag_if.sv ====
// lookup and update channel between the cache controller and its tag store
`timescale 1ns/1ps
interface ucp_tag_if #(parameter int IDX_W = 7, parameter int TAG_W = 21);
    logic [IDX_W-1:0] index;
    logic [TAG_W-1:0] look_tag;
    logic hit;
    logic [1:0] hit_way;
    logic [1:0] vic_way;
    logic vic_dirty;
    logic [TAG_W-1:0] vic_tag;
    logic upd_en;
    logic [1:0] upd_way;
    logic upd_valid;
    logic upd_dirty;
    logic [TAG_W-1:0] upd_tag;
    logic touch_en;
    logic [1:0] touch_way;

    modport ctrl (output index, look_tag, upd_en, upd_way, upd_valid, upd_dirty, upd_tag,
                  output touch_en, touch_way,
                  input hit, hit_way, vic_way, vic_dirty, vic_tag);
    modport store (input index, look_tag, upd_en, upd_way, upd_valid, upd_dirty, upd_tag,
                   input touch_en, touch_way,
                   output hit, hit_way, vic_way, vic_dirty, vic_tag);
endinterface : ucp_tag_if

// ==== rtl/ucp_tag_store.sv ====
// tag, valid, dirty and pseudo-lru state for the four ways
`timescale 1ns/1ps
module ucp_tag_store import ucp_pkg::*; #(
    parameter int IDX_W = 7,
    parameter int TAG_W = 21
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    ucp_tag_if.store tif
);
    localparam int SETS = 1 << IDX_W;

    logic [WAYS-1:0] way_valid;
    logic [WAYS-1:0] way_dirty;
    logic [WAYS-1:0] way_hit;
    logic [TAG_W-1:0] way_tag [WAYS];
    logic [PLRU_W-1:0] plru_mem [SETS];
    logic [PLRU_W-1:0] plru_cur;
    logic [PLRU_W-1:0] plru_nxt;
    logic [1:0] inv_way;
    logic any_inv;

    // one tag array and one valid/dirty vector per way, same index in all
    for (genvar w = 0; w < WAYS; w++) begin : g_way
        logic [SETS-1:0] valid_r;
        logic [SETS-1:0] dirty_r;
        logic [TAG_W-1:0] tag_mem [SETS];
        logic upd_here;

        assign upd_here = tif.upd_en && (tif.upd_way == 2'(w));
        assign way_valid[w] = valid_r[tif.index]; // one bit per whole line
        assign way_dirty[w] = dirty_r[tif.index];
        assign way_tag[w] = tag_mem[tif.index];
        assign way_hit[w] = way_valid[w] && (tag_mem[tif.index] == tif.look_tag);

        // flags are flops so that reset empties the whole cache at once
        always_ff @(posedge i_ref_clk or posedge i_rst) begin
            if (i_rst) begin
                valid_r <= '0;
                dirty_r <= '0;
            end else if (upd_here) begin
                valid_r[tif.index] <= tif.upd_valid;
                dirty_r[tif.index] <= tif.upd_dirty;
            end
        end

        // tags need no reset: they are only compared while valid
        always_ff @(posedge i_ref_clk) begin
            if (upd_here) begin
                tag_mem[tif.index] <= tif.upd_tag;
            end
        end
    end

    // hit encode and invalid-way-first victim choice
    always_comb begin
        tif.hit = |way_hit;
        tif.hit_way = 2'h0;
        inv_way = 2'h0;
        any_inv = 1'b0;
        for (int w = WAYS - 1; w >= 0; w--) begin
            if (way_hit[w]) begin
                tif.hit_way = 2'(w);
            end
            if (!way_valid[w]) begin
                inv_way = 2'(w);
                any_inv = 1'b1;
            end
        end
        plru_cur = plru_mem[tif.index];
        if (any_inv) begin
            tif.vic_way = inv_way;
        end else if (!plru_cur[0]) begin
            tif.vic_way = {1'b0, plru_cur[1]};
        end else begin
            tif.vic_way = {1'b1, plru_cur[2]};
        end
        tif.vic_dirty = way_valid[tif.vic_way] && way_dirty[tif.vic_way];
        tif.vic_tag = way_tag[tif.vic_way];
        // tree bits point away from the way just used
        plru_nxt = plru_cur;
        plru_nxt[0] = ~tif.touch_way[1];
        if (tif.touch_way[1]) begin
            plru_nxt[2] = ~tif.touch_way[0];
        end else begin
            plru_nxt[1] = ~tif.touch_way[0];
        end
    end

    // replacement history; an untouched set always has an invalid way to pick first
    always_ff @(posedge i_ref_clk) begin
        if (tif.touch_en) begin
            plru_mem[tif.index] <= plru_nxt;
        end
    end
endmodule : ucp_tag_store

// ==== test/ucp_cache_checker.sv ====
// port-level timing checks for the unified cache controller
`timescale 1ns/1ps
module ucp_cache_checker import ucp_pkg::*; #(
    parameter bit LARGE = 1'b0
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_wb_mode,
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic i_req_code,
    input wire logic i_req_cacheable,
    input wire logic [ADDR_W-1:0] i_req_addr,
    input wire logic [DATA_W-1:0] i_req_wdata,
    input wire logic i_bus_ack,
    input wire logic [DATA_W-1:0] i_bus_rdata,
    input wire logic o_req_ready,
    input wire logic o_rsp_valid,
    input wire logic o_rsp_code,
    input wire logic [DATA_W-1:0] o_rsp_rdata,
    input wire logic o_bus_req,
    input wire logic o_bus_write,
    input wire logic o_bus_burst,
    input wire logic [ADDR_W-1:0] o_bus_addr,
    input wire logic [DATA_W-1:0] o_bus_wdata
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    logic take;
    logic [1:0] word_w;
    logic [27:0] line_w;
    logic [2:0] acks_r;
    logic [2:0] acks_nxt;
    assign take = i_req_valid && o_req_ready;
    assign word_w = o_bus_addr[3:2];
    assign line_w = o_bus_addr[31:4];
    // acks seen so far in the open bus transaction, cleared whenever the bus closes
    always_comb begin
        acks_nxt = o_bus_req ? acks_r + {2'h0, i_bus_ack} : 3'h0;
    end
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            acks_r <= 3'h0;
        end else begin
            acks_r <= acks_nxt;
        end
    end
    a_take_busy: assert property (take |=> !o_req_ready)
        else $error("ready high after take");
    a_hit_answer: assert property (take && !i_req_write ##2 !o_bus_req |-> o_rsp_valid)
        else $error("hit not answered in two cycles");
    a_rsp_pulse: assert property (o_rsp_valid |=> !o_rsp_valid)
        else $error("response longer than one cycle");
    a_bypass_first: assert property (i_bus_ack && acks_r == 3'h0
        && o_bus_req && !o_bus_write |=> o_rsp_valid && o_rsp_rdata == $past(i_bus_rdata))
        else $error("first fill word not forwarded");
    a_burst_four: assert property (o_bus_req && o_bus_burst && i_bus_ack
        |=> (acks_r == 3'h4) == !o_bus_req)
        else $error("burst not closed after four transfers");
    a_single_one: assert property (o_bus_req && !o_bus_burst && i_bus_ack |=> !o_bus_req)
        else $error("single transfer not closed after one ack");
    a_wrap_order: assert property (o_bus_req && o_bus_burst && i_bus_ack && acks_r < 3'h3
        |=> o_bus_addr[3:2] == $past(word_w) + 2'h1 && $stable(line_w))
        else $error("burst address left the line or skipped a word");
    a_bus_hold: assert property (o_bus_req && !i_bus_ack
        |=> o_bus_req && $stable(o_bus_addr) && $stable(o_bus_wdata) && $stable(o_bus_write))
        else $error("bus request changed before its ack");
    a_fill_five: assert property (($rose(o_bus_req) && o_bus_burst && !o_bus_write
        && i_bus_ack) ##1 i_bus_ack [*3] |=> !o_bus_req && o_req_ready)
        else $error("prompt fill took more than five clocks");
    a_write_thru: assert property (take && i_req_write && !(LARGE && i_wb_mode) |->
        ##2 o_bus_req && o_bus_write && !o_bus_burst && o_bus_addr == $past(i_req_addr, 2))
        else $error("write not sent to the bus");
    c_hit: cover property (take && !i_req_write ##2 o_rsp_valid && !o_bus_req);
    c_evict: cover property (o_bus_req && o_bus_write && o_bus_burst);
    c_wb_hit: cover property (take && i_req_write && i_wb_mode ##2 o_req_ready && !o_bus_req);
endmodule : ucp_cache_checker

// ==== test/ucp_mem_model.sv ====
// behavioural external memory answering the cache bus
`timescale 1ns/1ps
module ucp_mem_model import ucp_pkg::*; (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [1:0] i_wait,
    input wire logic i_bus_req,
    input wire logic i_bus_write,
    input wire logic [ADDR_W-1:0] i_bus_addr,
    input wire logic [DATA_W-1:0] i_bus_wdata,
    output logic o_bus_ack,
    output logic [DATA_W-1:0] o_bus_rdata
);
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    int gap = 0;
    initial begin
        o_bus_ack = 1'b0;
        o_bus_rdata = 32'h0;
    end
    // answer between edges; with no wait one word moves on every clock
    always @(negedge i_ref_clk) begin
        if (!i_rst && i_bus_req && gap >= int'(i_wait)) begin
            o_bus_ack <= 1'b1;
            o_bus_rdata <= mem.exists(i_bus_addr) ? mem[i_bus_addr]
                : {i_bus_addr[15:0], ~i_bus_addr[15:0]};
            gap = 0;
        end else begin
            o_bus_ack <= 1'b0;
            o_bus_rdata <= ~o_bus_rdata; // released data never looks stale
            gap = i_bus_req ? gap + 1 : 0;
        end
    end
    // a written word lands on the edge that ends its transfer
    always @(posedge i_ref_clk) begin
        if (i_bus_req && o_bus_ack && i_bus_write) begin
            mem[i_bus_addr] = i_bus_wdata;
        end
    end
endmodule : ucp_mem_model

// ==== test/test_unified_l1_cache_policy.sv ====
// self-checking bench for the unified cache controller against a reference model
`timescale 1ns/1ps
module test_unified_l1_cache_policy import ucp_pkg::*;;
    logic ref_clk = 1'b0;
    logic rst, wb, vld, wr, cd, ca, ack, rdy, rv, rc, breq, bwr, bbst;
    logic [1:0] mwait;
    logic [31:0] addr, wdata, rdata, rd, baddr, bwd, r;
    logic breq_q = 1'b0;
    int failures = 0;
    int cmp_count = 0;
    int seed = 30;
    int n_txn = 0, n_bst = 0, n_wr = 0;
    logic [31:0] ex [logic [31:0]];
    logic [19:0] tg [256][4];
    bit vl [256][4];
    bit dt [256][4];
    bit [2:0] pl [256];
    int seq [9] = '{1, 2, 3, 4, 1, 5, 1, 4, 3};

    always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

    ucp_cache #(.LARGE(1'b1)) DUT (.i_ref_clk(ref_clk), .i_rst(rst), .i_wb_mode(wb),
        .i_req_valid(vld), .i_req_write(wr), .i_req_code(cd), .i_req_cacheable(ca),
        .i_req_addr(addr), .i_req_wdata(wdata), .i_bus_ack(ack), .i_bus_rdata(rdata),
        .o_req_ready(rdy), .o_rsp_valid(rv), .o_rsp_code(rc), .o_rsp_rdata(rd),
        .o_bus_req(breq), .o_bus_write(bwr), .o_bus_burst(bbst), .o_bus_addr(baddr),
        .o_bus_wdata(bwd));
    ucp_mem_model MEM (.i_ref_clk(ref_clk), .i_rst(rst), .i_wait(mwait), .i_bus_req(breq),
        .i_bus_write(bwr), .i_bus_addr(baddr), .i_bus_wdata(bwd), .o_bus_ack(ack),
        .o_bus_rdata(rdata));

    // count bus transactions as they open
    always @(posedge ref_clk) begin
        if (breq && !breq_q) begin
            n_txn++;
            n_bst += bbst;
            n_wr += bwr;
        end
        breq_q <= breq;
    end

    task automatic cmp_word(logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_bus(logic [5:0] got, logic [5:0] exp);
        cmp_word({26'h0, got}, {26'h0, exp});
    endtask : cmp_bus

    // tree pseudo-lru: each bit points at the half holding the next victim
    function automatic void touch(int s, int w);
        pl[s][0] = (w < 2);
        if (w < 2) pl[s][1] = !w[0];
        else pl[s][2] = !w[0];
    endfunction : touch

    // reference cache: expected bus {opened, bursts, writes}
    function automatic logic [5:0] model(bit w_, bit k_, logic [31:0] a);
        int s;
        int h;
        int v;
        s = int'(a[11:4]);
        h = -1;
        v = 4;
        for (int i = 0; i < 4; i++) if (vl[s][i] && tg[s][i] === a[31:12]) h = i;
        if (h >= 0) touch(s, h);
        if (w_ && h >= 0 && wb) dt[s][h] = 1'b1;
        if (w_) return (h >= 0 && wb) ? 6'h00 : 6'h11;
        if (h >= 0) return 6'h00;
        if (!k_) return 6'h10;
        for (int i = 3; i >= 0; i--) if (!vl[s][i]) v = i;
        if (v == 4) v = pl[s][0] ? 2 + pl[s][2] : pl[s][1];
        model = dt[s][v] ? 6'h29 : 6'h14;
        vl[s][v] = 1'b1;
        dt[s][v] = 1'b0;
        tg[s][v] = a[31:12];
        touch(s, v);
    endfunction : model

    // one request: held until taken, then wait for answer or completion
    task automatic op(bit w_, bit c_, bit k_, logic [31:0] a, logic [31:0] d);
        logic [5:0] e;
        logic [31:0] v;
        int t0;
        int b0;
        int r0;
        int n;
        e = model(w_, k_, a);
        v = ex.exists(a) ? ex[a] : {a[15:0], ~a[15:0]};
        if (w_) ex[a] = d;
        t0 = n_txn;
        b0 = n_bst;
        r0 = n_wr;
        @(negedge ref_clk);
        {vld, wr, cd, ca, addr, wdata} = {1'b1, w_, c_, k_, a, d};
        @(posedge ref_clk);
        while (rdy !== 1'b1) @(posedge ref_clk);
        @(negedge ref_clk);
        vld = 1'b0;
        n = 0;
        while ((w_ ? rdy : rv) !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        cmp_word(32'(n >= 200), 32'h0);
        if (!w_) cmp_word(rd, v);
        if (!w_) cmp_word({31'h0, rc}, {31'h0, c_});
        cmp_bus({2'(n_txn - t0), 2'(n_bst - b0), 2'(n_wr - r0)}, e);
    endtask : op

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    initial begin
        #(50_000 * CLK_PERIOD_NS);
        failures++;
        print_verdict();
    end

    initial begin
        {rst, wb, vld, wr, cd, ca, mwait} = 8'h80;
        addr = 32'h0;
        wdata = 32'h0;
        repeat (3) @(negedge ref_clk);
        cmp_word(rd | baddr | bwd, 32'h0);
        cmp_bus({1'b0, rdy, rv, rc, breq, bwr | bbst}, 6'h10);
        rst = 1'b0;
        $display("test done: reset");
        // five lines in one set: the fifth takes the pseudo-lru way
        for (int k = 0; k < 9; k++) op(0, k[0], 1, seq[k] * 32'h1000 + 32'h58, 0);
        $display("test done: set fill and replacement");
        repeat (2) op(0, 0, 0, 32'h8000_0120, 0);
        $display("test done: non-cacheable read");
        op(1, 0, 1, 32'h1058, 32'hCAFE_0001);
        op(0, 1, 1, 32'h1058, 0);
        op(1, 0, 1, 32'h7058, 32'hCAFE_0002);
        op(0, 0, 1, 32'h7058, 0);
        $display("test done: write-through");
        wb = 1'b1;
        op(1, 0, 1, 32'h7058, 32'hBEEF_0001);
        op(1, 0, 1, 32'h7054, 32'hBEEF_0002);
        for (int k = 8; k < 12; k++) op(0, 1, 1, k * 32'h1000 + 32'h5C, 0);
        op(0, 0, 1, 32'h7054, 0);
        $display("test done: write-back and eviction");
        mwait = 2'h2;
        op(0, 1, 1, 32'h2094, 0);
        op(0, 0, 0, 32'h8000_0094, 0);
        op(1, 0, 1, 32'h2098, 32'h1234_5678);
        $display("test done: slow memory");
        // random mix, few tags in two sets: hits, misses, evictions
        for (int i = 0; i < 300; i++) begin
            r = $random(seed);
            wb = r[12];
            mwait = r[14:13];
            op(r[15], r[17], r[0] | r[1],
               {!(r[0] | r[1]), 16'h0, r[6:4], 7'h0, r[7], r[9:8], 2'h0}, $random(seed));
        end
        $display("test done: random mix");
        print_verdict();
    end
endmodule : test_unified_l1_cache_policy

bind ucp_cache ucp_cache_checker #(.LARGE(LARGE)) u_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_wb_mode(i_wb_mode), .i_req_valid(i_req_valid), .i_req_write(i_req_write),
    .i_req_code(i_req_code), .i_req_cacheable(i_req_cacheable), .i_req_addr(i_req_addr),
    .i_req_wdata(i_req_wdata), .i_bus_ack(i_bus_ack), .i_bus_rdata(i_bus_rdata),
    .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_code(o_rsp_code),
    .o_rsp_rdata(o_rsp_rdata), .o_bus_req(o_bus_req), .o_bus_write(o_bus_write),
    .o_bus_burst(o_bus_burst), .o_bus_addr(o_bus_addr), .o_bus_wdata(o_bus_wdata));
